/* verilog/kcr_cfg.svh */
// Offsets, field positions, reset values and timing figures of the keyed configuration bank.
`ifndef KCR_CFG_SVH
`define KCR_CFG_SVH
`define KCR_PORT_KEY 10'h250
`define KCR_PORT_INDEX 10'h251
`define KCR_PORT_DATA 10'h252
`define KCR_KEY_STRAP_HI 8'h89
`define KCR_KEY_STRAP_LO 8'h88
`define KCR_KEY_LOCK 8'h00
`define KCR_IDX_LAST 8'h0b
`define KCR_IDX_R0 4'h0
`define KCR_IDX_R6 4'h6
`define KCR_IDX_R8 4'h8
`define KCR_IDX_R9 4'h9
`define KCR_R0_IDE_EN_N 7
`define KCR_R0_HD_SEL 6
`define KCR_R0_FDC_EN_N 5
`define KCR_R0_FDC_SEL 4
`define KCR_R0_MODE_MID 3
`define KCR_R0_MODE_LOW 2
`define KCR_R6_OSC_HIGH 6
`define KCR_R8_IDLE_HI 7
`define KCR_R8_IDLE_LO 6
`define KCR_R9_MODE_HIGH 7
`define KCR_R9_LOCK 6
`define KCR_CFG_RESET 8'h00
`define KCR_CLK_HZ 40000000
`define KCR_SETTLE_MS 128
`define KCR_IDLE_UNIT_MS 1
`define KCR_WB_CMD 8'h00
`define KCR_WB_STATUS 8'h04
`define KCR_WB_KEY 8'h08
`define KCR_HOST_KEY_RESET 8'h89
`define KCR_CMD_OP_READ 16
`endif

/* verilog/kcr_pkg.sv */
// Types shared by both ends of the keyed configuration bank.
package kcr_pkg;
    typedef enum logic [1:0] {
        KCR_OSC_NORMAL = 2'h0,
        KCR_OSC_HALT = 2'h1,
        KCR_OSC_IDLE_ARMED = 2'h2,
        KCR_OSC_IDLE_SLEEP = 2'h3
    } kcr_osc_t;
    typedef enum logic [6:0] {
        KCR_H_IDLE = 7'h01,
        KCR_H_KEY = 7'h02,
        KCR_H_INDEX = 7'h04,
        KCR_H_DATA = 7'h08,
        KCR_H_WAIT = 7'h10,
        KCR_H_LOCK = 7'h20,
        KCR_H_SETTLE = 7'h40
    } kcr_host_state_t;
endpackage : kcr_pkg

/* verilog/kcr_io_if.sv */
// I/O port bus between the host controller and the configuration bank.
`timescale 1ns/1ps
interface kcr_io_if;
    logic [9:0] io_addr;
    logic [7:0] io_wdata;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_rdata;
    logic io_rack;
    modport dev (
        input io_addr,
        input io_wdata,
        input io_wr,
        input io_rd,
        output io_rdata,
        output io_rack
    );
    modport host (
        output io_addr,
        output io_wdata,
        output io_wr,
        output io_rd,
        input io_rdata,
        input io_rack
    );
endinterface : kcr_io_if

/* verilog/kcr_dev.sv */
// Keyed, indexed configuration register bank with power-down control.
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`include "kcr_cfg.svh"

//////////////////////////////////////////////////////////////////////////////////////////////
module kcr_dev
    import kcr_pkg::*;
#(
    parameter int NUM_REGS = 12,
    parameter int IDLE_UNIT_CYCLES = `KCR_IDLE_UNIT_MS * (`KCR_CLK_HZ / 1000)
) (
    // Clock and warm reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Host I/O port bus
    kcr_io_if.dev io,
    // Cold reset and power-on straps
    input wire logic master_reset_in,
    input wire logic game_read_strobe,
    input wire logic strap_hard_disk_enable_n,
    input wire logic strap_hard_disk_address,
    input wire logic strap_floppy_enable_n,
    input wire logic strap_floppy_address,
    // Idle conditions for automatic power-down
    input wire logic floppy_busy,
    input wire logic floppy_motor_on,
    input wire logic [1:0] serial_irq_active,
    input wire logic [1:0] serial_out_idle,
    input wire logic [1:0] serial_in_idle,
    // Configuration outputs
    output logic hard_disk_port_enable_n,
    output logic hard_disk_address_select,
    output logic floppy_port_enable_n,
    output logic floppy_address_select,
    output logic [2:0] printer_mode,
    output logic config_locked,
    // Clock control outputs
    output logic osc_run,
    output logic core_clk_en,
    output logic floppy_clk_en
);

    //////////////////////////////////////////////////////////////////////////////////////////
    // Storage and decode.

    logic [7:0] cfg [NUM_REGS];
    logic [7:0] unlock_key;
    logic unlocked;
    logic [7:0] index_sel;
    logic [31:0] idle_count;
    logic [5:0] idle_prev;
    logic [5:0] idle_now;
    logic all_idle;
    logic idle_changed;
    logic port_access;
    logic access_ok;
    logic index_valid;
    logic data_write;
    logic idle_expire;
    logic idle_wake;
    logic [31:0] idle_target;
    logic next_core_en;
    kcr_osc_t osc_sel;

    // True when the bus address hits the given port.
    function automatic logic kcr_hit(input logic [9:0] addr, input logic [9:0] port);
        kcr_hit = (addr == port);
    endfunction : kcr_hit

    // A relock through the lock bit takes effect on top of the key state.
    assign access_ok = unlocked && !cfg[`KCR_IDX_R9][`KCR_R9_LOCK];
    assign index_valid = (index_sel <= `KCR_IDX_LAST);
    assign data_write = io.io_wr && kcr_hit(io.io_addr, `KCR_PORT_DATA) && access_ok
        && index_valid;
    assign port_access = (io.io_wr || io.io_rd) && (kcr_hit(io.io_addr, `KCR_PORT_KEY)
        || kcr_hit(io.io_addr, `KCR_PORT_INDEX) || kcr_hit(io.io_addr, `KCR_PORT_DATA));
    assign osc_sel = kcr_osc_t'(cfg[`KCR_IDX_R0][1:0]);

    //////////////////////////////////////////////////////////////////////////////////////////
    // Idle detection for automatic power-down.

    // Any transition of a condition restarts the count, not only a loss of idleness.
    assign idle_now = {floppy_busy, floppy_motor_on, serial_irq_active, master_reset_in,
        port_access};
    assign all_idle = !floppy_busy && !floppy_motor_on && (serial_irq_active == 2'h0)
        && !master_reset_in && (&serial_out_idle) && (&serial_in_idle)
        && !port_access;
    assign idle_changed = (idle_now != idle_prev);
    assign idle_target = 32'(IDLE_UNIT_CYCLES)
        << cfg[`KCR_IDX_R8][`KCR_R8_IDLE_HI:`KCR_R8_IDLE_LO];
    assign idle_expire = (osc_sel == KCR_OSC_IDLE_ARMED) && all_idle && !idle_changed
        && (idle_count >= idle_target - 32'h1);
    assign idle_wake = (osc_sel == KCR_OSC_IDLE_SLEEP) && !all_idle;

    // Remember the conditions so that a change can be seen.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            idle_prev <= 6'h00;
        end else begin
            idle_prev <= idle_now;
        end
    end

    // Idle-time counter, running only while armed and undisturbed.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            idle_count <= 32'h0;
        end else if (osc_sel != KCR_OSC_IDLE_ARMED || !all_idle || idle_changed
            || idle_expire) begin
            idle_count <= 32'h0;
        end else begin
            idle_count <= idle_count + 32'h1;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // Key and index state.

    // The accepted key is caught from the strap while cold reset is held.
    always_ff @(posedge core_clk) begin
        if (master_reset_in) begin
            unlock_key <= game_read_strobe ? `KCR_KEY_STRAP_HI : `KCR_KEY_STRAP_LO;
        end
    end

    // Any key-port write decides the lock state: the key opens, all else closes.
    always_ff @(posedge core_clk) begin
        if (!reset_n || master_reset_in) begin
            unlocked <= 1'b0;
        end else if (io.io_wr && kcr_hit(io.io_addr, `KCR_PORT_KEY)) begin
            unlocked <= (io.io_wdata == unlock_key);
        end
    end

    // Index writes count only once the bank is open.
    always_ff @(posedge core_clk) begin
        if (!reset_n || master_reset_in) begin
            index_sel <= 8'h00;
        end else if (io.io_wr && kcr_hit(io.io_addr, `KCR_PORT_INDEX) && access_ok) begin
            index_sel <= io.io_wdata;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // Configuration registers; warm reset leaves them alone.

    // Power-down transitions come first so that a host write in the same cycle wins.
    always_ff @(posedge core_clk) begin
        if (master_reset_in) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                cfg[i] <= `KCR_CFG_RESET;
            end
            cfg[`KCR_IDX_R0] <= {strap_hard_disk_enable_n, strap_hard_disk_address,
                strap_floppy_enable_n, strap_floppy_address, 4'h0};
        end else begin
            if (idle_expire) begin
                cfg[`KCR_IDX_R0][1:0] <= KCR_OSC_IDLE_SLEEP;
            end else if (idle_wake) begin
                cfg[`KCR_IDX_R0][1:0] <= KCR_OSC_IDLE_ARMED;
            end
            if (data_write) begin
                cfg[index_sel[3:0]] <= io.io_wdata;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // Read answers.

    // Key and index ports answer zero; a locked data port answers zero too.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            io.io_rack <= 1'b0;
            io.io_rdata <= 8'h00;
        end else begin
            io.io_rack <= io.io_rd && port_access;
            if (io.io_rd && kcr_hit(io.io_addr, `KCR_PORT_DATA) && access_ok && index_valid) begin
                io.io_rdata <= cfg[index_sel[3:0]];
            end else begin
                io.io_rdata <= 8'h00;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // Clock control.

    // The internal clock is gated in the three stopped states.
    assign next_core_en = !((osc_sel == KCR_OSC_NORMAL && cfg[`KCR_IDX_R6][`KCR_R6_OSC_HIGH])
        || osc_sel == KCR_OSC_HALT || osc_sel == KCR_OSC_IDLE_SLEEP);

    // Registered enables; they trail the select bits by one cycle.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            osc_run <= 1'b1;
            core_clk_en <= 1'b1;
            floppy_clk_en <= 1'b1;
            config_locked <= 1'b1;
        end else begin
            osc_run <= (osc_sel != KCR_OSC_HALT);
            core_clk_en <= next_core_en;
            floppy_clk_en <= next_core_en && !cfg[`KCR_IDX_R0][`KCR_R0_FDC_EN_N];
            config_locked <= !access_ok;
        end
    end

    // Configuration fields straight off their register bits.
    assign hard_disk_port_enable_n = cfg[`KCR_IDX_R0][`KCR_R0_IDE_EN_N];
    assign hard_disk_address_select = cfg[`KCR_IDX_R0][`KCR_R0_HD_SEL];
    assign floppy_port_enable_n = cfg[`KCR_IDX_R0][`KCR_R0_FDC_EN_N];
    assign floppy_address_select = cfg[`KCR_IDX_R0][`KCR_R0_FDC_SEL];
    assign printer_mode = {cfg[`KCR_IDX_R9][`KCR_R9_MODE_HIGH],
        cfg[`KCR_IDX_R0][`KCR_R0_MODE_MID], cfg[`KCR_IDX_R0][`KCR_R0_MODE_LOW]};

endmodule : kcr_dev

/* verilog/kcr_host.sv */
// Host controller: runs keyed configuration sequences ordered over Wishbone.
`timescale 1ns/1ps
`include "kcr_cfg.svh"

module kcr_host
    import kcr_pkg::*;
#(
    parameter int SETTLE_CYCLES = `KCR_SETTLE_MS * (`KCR_CLK_HZ / 1000)
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Device I/O port bus
    kcr_io_if.host io
);

    //////////////////////////////////////////////////////////////////////////////////////////
    // Command registers and sequencer state.

    kcr_host_state_t state;
    logic [7:0] key_value;
    logic [3:0] cmd_index;
    logic [7:0] cmd_data;
    logic cmd_read;
    logic [7:0] read_data;
    logic osc_stopped;
    logic settle_due;
    logic [31:0] settle_count;
    logic req;
    logic start;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign start = req && wb_we_i && (wb_adr_i == `KCR_WB_CMD) && (&wb_sel_i[2:0])
        && (state == KCR_H_IDLE);

    // Bus answer one cycle after the request; busy refuses new commands silently.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            key_value <= `KCR_HOST_KEY_RESET;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h0;
            if (req && !wb_we_i && wb_adr_i == `KCR_WB_STATUS) begin
                wb_dat_o <= {16'h0, read_data, 6'h0, state == KCR_H_SETTLE,
                    state != KCR_H_IDLE};
            end else if (req && !wb_we_i && wb_adr_i == `KCR_WB_KEY) begin
                wb_dat_o <= {24'h0, key_value};
            end
            if (req && wb_we_i && wb_adr_i == `KCR_WB_KEY && wb_sel_i[0]) begin
                key_value <= wb_dat_i[7:0];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // Sequencer: key, index, data, relock, then settling when waking from halt.

    // Each step drives its strobe for exactly one cycle.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state <= KCR_H_IDLE;
            io.io_addr <= 10'h0;
            io.io_wdata <= 8'h00;
            io.io_wr <= 1'b0;
            io.io_rd <= 1'b0;
            cmd_index <= 4'h0;
            cmd_data <= 8'h00;
            cmd_read <= 1'b0;
            read_data <= 8'h00;
            osc_stopped <= 1'b0;
            settle_due <= 1'b0;
            settle_count <= 32'h0;
        end else begin
            io.io_wr <= 1'b0;
            io.io_rd <= 1'b0;
            unique case (state)
                KCR_H_IDLE: begin
                    if (start) begin
                        cmd_index <= wb_dat_i[3:0];
                        cmd_data <= wb_dat_i[15:8];
                        cmd_read <= wb_dat_i[`KCR_CMD_OP_READ];
                        io.io_addr <= `KCR_PORT_KEY;
                        io.io_wdata <= key_value;
                        io.io_wr <= 1'b1;
                        state <= KCR_H_KEY;
                    end
                end
                KCR_H_KEY: begin
                    io.io_addr <= `KCR_PORT_INDEX;
                    io.io_wdata <= {4'h0, cmd_index};
                    io.io_wr <= 1'b1;
                    state <= KCR_H_INDEX;
                end
                KCR_H_INDEX: begin
                    io.io_addr <= `KCR_PORT_DATA;
                    io.io_wdata <= cmd_data;
                    io.io_wr <= !cmd_read;
                    io.io_rd <= cmd_read;
                    if (!cmd_read && cmd_index == `KCR_IDX_R0) begin
                        settle_due <= osc_stopped && (cmd_data[1:0] != KCR_OSC_HALT);
                        osc_stopped <= (cmd_data[1:0] == KCR_OSC_HALT);
                    end
                    state <= KCR_H_DATA;
                end
                KCR_H_DATA: begin
                    if (cmd_read) begin
                        state <= KCR_H_WAIT;
                    end else begin
                        io.io_addr <= `KCR_PORT_KEY;
                        io.io_wdata <= `KCR_KEY_LOCK;
                        io.io_wr <= 1'b1;
                        state <= KCR_H_LOCK;
                    end
                end
                KCR_H_WAIT: begin
                    if (io.io_rack) begin
                        read_data <= io.io_rdata;
                        io.io_addr <= `KCR_PORT_KEY;
                        io.io_wdata <= `KCR_KEY_LOCK;
                        io.io_wr <= 1'b1;
                        state <= KCR_H_LOCK;
                    end
                end
                KCR_H_LOCK: begin
                    settle_count <= 32'h0;
                    settle_due <= 1'b0;
                    state <= settle_due ? KCR_H_SETTLE : KCR_H_IDLE;
                end
                KCR_H_SETTLE: begin
                    settle_count <= settle_count + 32'h1;
                    if (settle_count >= 32'(SETTLE_CYCLES) - 32'h1) begin
                        state <= KCR_H_IDLE;
                    end
                end
                default: begin
                    state <= KCR_H_IDLE;
                end
            endcase
        end
    end

endmodule : kcr_host

/* dv/kcr_asserts.sv */
// Concurrent checks on the I/O port link between the host controller and the bank.
`timescale 1ns/1ps
`include "kcr_cfg.svh"
module kcr_asserts (
    // Clock and warm reset
    input wire logic core_clk,
    input wire logic reset_n,
    // I/O port link
    input wire logic [9:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_rdata,
    input wire logic io_rack
);
    // Every check runs on the core clock and is muted during warm reset.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Device side: a data read is answered in the next cycle, and only then.
    rd_answer_a:
    assert property (io_rd && io_addr == `KCR_PORT_DATA |=> io_rack)
        else $error("Data read left without an answer.");
    rack_cause_a:
    assert property (io_rack |-> $past(io_rd) && $past(io_addr) == `KCR_PORT_DATA)
        else $error("Read answer without a data read.");
    // An index past the last register must read as zero.
    high_index_a:
    assert property (io_rd && io_addr == `KCR_PORT_DATA && $past(io_wdata) > `KCR_IDX_LAST
        |=> io_rack && io_rdata == 8'h00)
        else $error("Read beyond the last register returned data.");

    ////////////////////////////////////////////////////////////////////////////////////////
    // Host side: key, index, data and relock come in that order, back to back except for one idle cycle before the relock after a read.
    index_after_key_a:
    assert property (io_wr && io_addr == `KCR_PORT_INDEX
        |-> $past(io_wr) && $past(io_addr) == `KCR_PORT_KEY)
        else $error("Index written without a key just before.");
    data_after_index_a:
    assert property ((io_wr || io_rd) && io_addr == `KCR_PORT_DATA
        |-> $past(io_wr) && $past(io_addr) == `KCR_PORT_INDEX)
        else $error("Data access without an index just before.");
    relock_write_a:
    assert property (io_wr && io_addr == `KCR_PORT_DATA
        |=> io_wr && io_addr == `KCR_PORT_KEY && io_wdata == `KCR_KEY_LOCK)
        else $error("Data write not followed by a relock.");
    relock_read_a:
    assert property (io_rd && io_addr == `KCR_PORT_DATA
        |-> ##2 io_wr && io_addr == `KCR_PORT_KEY && io_wdata == `KCR_KEY_LOCK)
        else $error("Data read not followed by a relock.");
    strobe_excl_a:
    assert property (!(io_wr && io_rd))
        else $error("Read and write strobes together.");
endmodule : kcr_asserts

/* dv/keyed_config_register_access_tb.sv */
// Self-checking bench: host controller and configuration bank joined back to back.
`timescale 1ns/1ps
`include "kcr_cfg.svh"
module keyed_config_register_access_tb;
    logic core_clk, reset_n, master_reset_in, game_read_strobe, settle_seen;
    logic wb_cyc, wb_stb, wb_we, wb_ack;
    logic [3:0] strap;
    logic [4:0] brk;
    logic [7:0] wb_adr, q;
    logic [31:0] wb_wdat, wb_rdat, r;
    logic hd_en_n, hd_sel, fl_en_n, fl_sel, locked, osc_run, core_en, fl_clk_en;
    logic [2:0] pmode, mode;
    int fails, samples_checked;
    // Rows: index, write data, expected readback; index 0ch lies past the bank.
    logic [19:0] rows [5] = '{20'h05c5c, 20'h98080, 20'h2a5a5, 20'hb3c3c, 20'hc7700};

    ////////////////////////////////////////////////////////////////////////////////////////
    // Both ends, the link between them, and the link checker.
    kcr_io_if io_bus ();
    kcr_host #(.SETTLE_CYCLES(8)) u_kcr_host (.core_clk(core_clk), .reset_n(reset_n),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hf), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .io(io_bus));
    // Short idle unit keeps the power-down waits to a few cycles.
    kcr_dev #(.NUM_REGS(12), .IDLE_UNIT_CYCLES(4)) u_kcr_dev (.core_clk(core_clk),
        .reset_n(reset_n), .io(io_bus), .master_reset_in(master_reset_in),
        .game_read_strobe(game_read_strobe), .strap_hard_disk_enable_n(strap[3]),
        .strap_hard_disk_address(strap[2]), .strap_floppy_enable_n(strap[1]),
        .strap_floppy_address(strap[0]), .floppy_busy(brk[0]), .floppy_motor_on(brk[1]),
        .serial_irq_active({1'b0, brk[2]}), .serial_out_idle({1'b1, ~brk[3]}),
        .serial_in_idle({~brk[4], 1'b1}), .hard_disk_port_enable_n(hd_en_n),
        .hard_disk_address_select(hd_sel), .floppy_port_enable_n(fl_en_n),
        .floppy_address_select(fl_sel), .printer_mode(pmode), .config_locked(locked),
        .osc_run(osc_run), .core_clk_en(core_en), .floppy_clk_en(fl_clk_en));
    kcr_asserts u_kcr_asserts (.core_clk(core_clk), .reset_n(reset_n),
        .io_addr(io_bus.io_addr), .io_wdata(io_bus.io_wdata), .io_wr(io_bus.io_wr),
        .io_rd(io_bus.io_rd), .io_rdata(io_bus.io_rdata), .io_rack(io_bus.io_rack));

    ////////////////////////////////////////////////////////////////////////////////////////
    // Free-running 40 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Compare tasks, one for bytes and one for flags.
    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk8
    task automatic chk1(input string name, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask : chk1

    // One classic Wishbone cycle; the request holds until ack is sampled high.
    task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d,
            output logic [31:0] o);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_wdat <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        o = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge core_clk);
    endtask : wb

    // One keyed sequence, then status polled until neither busy nor settling.
    task automatic cfg(input logic [3:0] idx, input logic [7:0] d, input logic rd,
            output logic [7:0] o);
        logic [31:0] s;
        int n;
        wb(`KCR_WB_CMD, 1'b1, {15'h0, rd, d, 4'h0, idx}, s);
        n = 0;
        s = 32'h1;
        settle_seen = 1'b0;
        while (s[1:0] !== 2'b00 && n < 60) begin
            wb(`KCR_WB_STATUS, 1'b0, 32'h0, s);
            settle_seen |= s[1];
            n++;
        end
        if (n >= 60) fails++;
        o = s[15:8];
    endtask : cfg

    task automatic summarize();
        if (fails == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    // Watchdog: the whole sequence needs a few thousand cycles at most.
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Main sequence: cold start, table rows, then the awkward cases.
    initial begin
        {reset_n, master_reset_in, game_read_strobe, strap, brk} = {3'b011, 4'b1001, 5'h0};
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} = '0;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        master_reset_in <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk8("straps", 8'h09, {4'h0, hd_en_n, hd_sel, fl_en_n, fl_sel});
        chk8("mode", 8'h00, {5'h0, pmode});
        chk1("locked", 1'b1, locked);
        wb(`KCR_WB_KEY, 1'b0, 32'h0, r);
        chk8("host_key", `KCR_HOST_KEY_RESET, r[7:0]);
        wb(8'h0c, 1'b0, 32'h0, r);
        chk8("unmapped", 8'h00, r[7:0]);
        for (int i = 0; i < 5; i++) begin
            cfg(rows[i][19:16], rows[i][15:8], 1'b0, q);
            cfg(rows[i][19:16], 8'h00, 1'b1, q);
            chk8("readback", rows[i][7:0], q);
        end
        chk8("fields", 8'h05, {4'h0, hd_en_n, hd_sel, fl_en_n, fl_sel});
        chk1("fl_clk", 1'b1, fl_clk_en);
        // Every printer mode code, high bit from register nine.
        for (int m = 0; m < 8; m++) begin
            mode = m[2:0];
            cfg(4'h9, {mode[2], 7'h0}, 1'b0, q);
            cfg(4'h0, {4'h5, mode[1:0], 2'b00}, 1'b0, q);
            chk8("mode", {5'h0, mode}, {5'h0, pmode});
        end
        cfg(4'h0, 8'h7c, 1'b0, q);
        repeat (2) @(posedge core_clk);
        chk1("fl_clk", 1'b0, fl_clk_en);
        // Clock gating, immediate power-down and wake with settling.
        cfg(4'h6, 8'h40, 1'b0, q);
        repeat (2) @(posedge core_clk);
        chk1("core_en", 1'b0, core_en);
        cfg(4'h6, 8'h00, 1'b0, q);
        repeat (2) @(posedge core_clk);
        chk1("core_en", 1'b1, core_en);
        cfg(4'h0, 8'h5d, 1'b0, q);
        repeat (2) @(posedge core_clk);
        chk8("osc_core", 8'h00, {6'h0, osc_run, core_en});
        cfg(4'h0, 8'h5c, 1'b0, q);
        chk1("settle", 1'b1, settle_seen);
        chk8("osc_core", 8'h03, {6'h0, osc_run, core_en});
        // Automatic power-down: sleep, then the floppy and serial idle conditions each break it in turn.
        cfg(4'h8, 8'h00, 1'b0, q);
        cfg(4'h0, 8'h5e, 1'b0, q);
        repeat (20) @(posedge core_clk);
        chk8("osc_core", 8'h02, {6'h0, osc_run, core_en});
        for (int b = 0; b < 5; b++) begin
            brk <= 5'h1 << b;
            repeat (4) @(posedge core_clk);
            chk1("core_en", 1'b1, core_en);
            brk <= 5'h0;
            repeat (20) @(posedge core_clk);
            chk1("core_en", 1'b0, core_en);
        end
        cfg(4'h0, 8'h00, 1'b1, q);
        chk8("reg0", 8'h5e, q);
        cfg(4'h8, 8'hc0, 1'b0, q);
        repeat (12) @(posedge core_clk);
        chk1("core_en", 1'b1, core_en);
        repeat (40) @(posedge core_clk);
        chk1("core_en", 1'b0, core_en);
        cfg(4'h0, 8'h5c, 1'b0, q);
        // Wrong key: writes dropped, reads empty.
        wb(`KCR_WB_KEY, 1'b1, 32'h88, r);
        cfg(4'h2, 8'h11, 1'b0, q);
        cfg(4'h2, 8'h00, 1'b1, q);
        chk8("bad_key", 8'h00, q);
        wb(`KCR_WB_KEY, 1'b1, 32'h89, r);
        cfg(4'h2, 8'h00, 1'b1, q);
        chk8("reg2", 8'ha5, q);
        // Warm reset keeps the configuration.
        reset_n <= 1'b0;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        cfg(4'h2, 8'h00, 1'b1, q);
        chk8("warm", 8'ha5, q);
        // Lock bit blocks everything after it.
        cfg(4'h9, 8'hc0, 1'b0, q);
        cfg(4'h0, 8'h7c, 1'b0, q);
        chk1("fl_en_n", 1'b0, fl_en_n);
        cfg(4'h9, 8'h00, 1'b1, q);
        chk8("lock_rd", 8'h00, q);
        // Cold reset with other straps and the other key.
        master_reset_in <= 1'b1;
        strap <= 4'b0110;
        game_read_strobe <= 1'b0;
        repeat (4) @(posedge core_clk);
        master_reset_in <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk8("straps", 8'h06, {4'h0, hd_en_n, hd_sel, fl_en_n, fl_sel});
        chk8("mode", 8'h00, {5'h0, pmode});
        cfg(4'h2, 8'h3c, 1'b0, q);
        wb(`KCR_WB_KEY, 1'b1, 32'h88, r);
        cfg(4'h2, 8'h00, 1'b1, q);
        chk8("cold", 8'h00, q);
        cfg(4'h2, 8'h3c, 1'b0, q);
        cfg(4'h2, 8'h00, 1'b1, q);
        chk8("key88", 8'h3c, q);
        summarize();
    end
endmodule : keyed_config_register_access_tb
